// File: nsx_defines.vh
// constants for the nibble swap / xor / direction-load execute block
`ifndef NSX_DEFINES_VH
`define NSX_DEFINES_VH

// ----------------------------------------------------------------------
// instruction word layout (14-bit word)
// ----------------------------------------------------------------------
`define NSX_IW_W        14
`define NSX_OPF_HI      13
`define NSX_OPF_LO      8
`define NSX_DEST_BIT    7
`define NSX_FADDR_HI    6
`define NSX_FADDR_LO    0
`define NSX_LIT_HI      7
`define NSX_LIT_LO      0
`define NSX_NIB_HI_HI   7
`define NSX_NIB_HI_LO   4
`define NSX_NIB_LO_HI   3
`define NSX_NIB_LO_LO   0

// ----------------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------------
`define NSX_OP_SWAP     6'h0e
`define NSX_OP_XORLIT   6'h3a
`define NSX_OP_XORFILE  6'h06
`define NSX_DIRLD_HI    11'h00c
`define NSX_DIRLD_W     11
`define NSX_PSEL_HI     2
`define NSX_PSEL_LO     0
`define NSX_PSEL_MIN    3'h5
`define NSX_PSEL_MAX    3'h7
`define NSX_DIRLD_LO    3
`define NSX_PSEL_A      3'h5
`define NSX_PSEL_B      3'h6
`define NSX_PSEL_C      3'h7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define NSX_ACC_RST     8'h00
`define NSX_DIR_RST     8'hff
`define NSX_ZERO_BYTE   8'h00
`define NSX_ZF_RST      1'b0
`define NSX_WREN_RST    1'b0

`endif

// File: nsx_op_decode.v
// instruction word decoder for the execute block
`timescale 1ns/100ps
`include "nsx_defines.vh"

module nsx_op_decode
(
    input  wire [13:0] instrWord,
    input  wire        instrValid,
    output wire        isSwap,
    output wire        isXorLit,
    output wire        isXorFile,
    output wire        isDirLoad
);

// ----------------------------------------------------------------------
// opcode match
// ----------------------------------------------------------------------
wire [5:0] opField;
wire [2:0] portSel;
assign opField = instrWord[`NSX_OPF_HI:`NSX_OPF_LO];
assign portSel = instrWord[`NSX_PSEL_HI:`NSX_PSEL_LO];

// one-hot class flags, qualified by a valid word
assign isSwap    = instrValid && (opField == `NSX_OP_SWAP);
assign isXorLit  = instrValid && (opField == `NSX_OP_XORLIT);
assign isXorFile = instrValid && (opField == `NSX_OP_XORFILE);
// operands outside 5..7 do nothing
assign isDirLoad = instrValid
                && (instrWord[`NSX_IW_W-1:`NSX_DIRLD_LO] == `NSX_DIRLD_HI)
                && (portSel >= `NSX_PSEL_MIN)
                && (portSel <= `NSX_PSEL_MAX);

endmodule // nsx_op_decode

// File: nsx_exec.v
// execute logic for nibble swap, xor and legacy port direction load
`timescale 1ns/100ps
`include "nsx_defines.vh"


module nsx_exec
(
    input  wire        clk,
    input  wire        srst,
    input  wire [13:0] instrWord,
    input  wire        instrValid,
    input  wire [7:0]  fileRdData,
    output wire [6:0]  fileAddr,
    output wire [7:0]  fileWrData,
    output wire        fileWrEn,
    output wire [7:0]  acc,
    output wire        zeroFlag,
    output wire [7:0]  dirA,
    output wire [7:0]  dirB,
    output wire [7:0]  dirC
);

// ----------------------------------------------------------------------
// decode
// ----------------------------------------------------------------------
wire isSwap;
wire isXorLit;
wire isXorFile;
wire isDirLoad;

nsx_op_decode uDecode
(
    .instrWord  (instrWord),
    .instrValid (instrValid),
    .isSwap     (isSwap),
    .isXorLit   (isXorLit),
    .isXorFile  (isXorFile),
    .isDirLoad  (isDirLoad)
);

// ----------------------------------------------------------------------
// operand fields
// ----------------------------------------------------------------------
wire       destFile;
wire [7:0] litVal;
wire [2:0] portSel;
assign destFile = instrWord[`NSX_DEST_BIT];
assign litVal   = instrWord[`NSX_LIT_HI:`NSX_LIT_LO];
assign portSel  = instrWord[`NSX_PSEL_HI:`NSX_PSEL_LO];
// file address goes to the register file read port
assign fileAddr = instrWord[`NSX_FADDR_HI:`NSX_FADDR_LO];

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
function [7:0] swapNib;
    input [7:0] b;
    begin
        swapNib = {b[`NSX_NIB_LO_HI:`NSX_NIB_LO_LO],
                   b[`NSX_NIB_HI_HI:`NSX_NIB_HI_LO]};
    end
endfunction

function isZero;
    input [7:0] b;
    begin
        isZero = (b == `NSX_ZERO_BYTE);
    end
endfunction

function portHit;
    input [2:0] sel;
    input [2:0] code;
    begin
        portHit = (sel == code);
    end
endfunction

// ----------------------------------------------------------------------
// result datapath
// ----------------------------------------------------------------------
reg [7:0] result;
reg       toFile;
reg       toAcc;
reg       setsZero;

// combinational result and destination select
always @*
begin
    result   = `NSX_ZERO_BYTE;
    toFile   = 1'b0;
    toAcc    = 1'b0;
    setsZero = 1'b0;
    if (isSwap)
    begin
        result = swapNib(fileRdData);
        toFile = destFile;
        toAcc  = !destFile;
    end
    else if (isXorLit)
    begin
        result   = acc ^ litVal;
        toAcc    = 1'b1;
        setsZero = 1'b1;
    end
    else if (isXorFile)
    begin
        result   = acc ^ fileRdData;
        toFile   = destFile;
        toAcc    = !destFile;
        setsZero = 1'b1;
    end
end

// ----------------------------------------------------------------------
// architectural state
// ----------------------------------------------------------------------
reg  [7:0] acc_r;
reg  [7:0] acc_nxt;
reg        zeroFlag_r;
reg        zeroFlag_nxt;
reg        fileWrEn_r;
reg        fileWrEn_nxt;
reg  [7:0] fileWrData_r;
reg  [7:0] fileWrData_nxt;
reg  [7:0] dirA_r;
reg  [7:0] dirA_nxt;
reg  [7:0] dirB_r;
reg  [7:0] dirB_nxt;
reg  [7:0] dirC_r;
reg  [7:0] dirC_nxt;

// ----------------------------------------------------------------------
// next values
// ----------------------------------------------------------------------
// accumulator, zero flag and write data hold unless an op targets them; write enable follows toFile
always @*
begin
    acc_nxt        = acc_r;
    zeroFlag_nxt   = zeroFlag_r;
    fileWrEn_nxt   = toFile;
    fileWrData_nxt = fileWrData_r;
    if (toFile)
        fileWrData_nxt = result;
    if (toAcc)
        acc_nxt = result;
    if (setsZero)
        zeroFlag_nxt = isZero(result);
end

// direction registers load from the accumulator; flags never touched
always @*
begin
    dirA_nxt = dirA_r;
    dirB_nxt = dirB_r;
    dirC_nxt = dirC_r;
    if (isDirLoad)
    begin
        if (portHit(portSel, `NSX_PSEL_A))
            dirA_nxt = acc_r;
        if (portHit(portSel, `NSX_PSEL_B))
            dirB_nxt = acc_r;
        if (portHit(portSel, `NSX_PSEL_C))
            dirC_nxt = acc_r;
    end
end

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
// accumulator, zero flag and registered file write port
always @(posedge clk)
begin
    if (srst)
    begin
        acc_r        <= `NSX_ACC_RST;
        zeroFlag_r   <= `NSX_ZF_RST;
        fileWrEn_r   <= `NSX_WREN_RST;
        fileWrData_r <= `NSX_ZERO_BYTE;
    end
    else
    begin
        acc_r        <= acc_nxt;
        zeroFlag_r   <= zeroFlag_nxt;
        fileWrEn_r   <= fileWrEn_nxt;      // one-cycle strobe
        fileWrData_r <= fileWrData_nxt;
    end
end

// direction registers reset to all inputs
always @(posedge clk)
begin
    if (srst)
    begin
        dirA_r <= `NSX_DIR_RST;
        dirB_r <= `NSX_DIR_RST;
        dirC_r <= `NSX_DIR_RST;
    end
    else
    begin
        dirA_r <= dirA_nxt;
        dirB_r <= dirB_nxt;
        dirC_r <= dirC_nxt;
    end
end

// ----------------------------------------------------------------------
// outputs straight from flip-flops
// ----------------------------------------------------------------------
assign acc        = acc_r;
assign zeroFlag   = zeroFlag_r;
assign fileWrEn   = fileWrEn_r;
assign fileWrData = fileWrData_r;
assign dirA       = dirA_r;
assign dirB       = dirB_r;
assign dirC       = dirC_r;

endmodule // nsx_exec

// File: nsx_regfile_model.sv
// register file partner for the execute block
`timescale 1ns/100ps
module nsx_regfile_model
(
    input  wire logic       clk,
    input  wire logic [6:0] fileAddr,
    input  wire logic [7:0] fileWrData,
    input  wire logic       fileWrEn,
    output logic      [7:0] fileRdData
);
    logic [7:0] mem [0:127];
    logic [6:0] addrQ;
    // preset contents, same formula as the bench model
    initial for (int i = 0; i < 128; i++) mem[i] = i[7:0] ^ 8'h5a;
    // write lands one cycle late at the latched address
    always @(posedge clk)
    begin
        addrQ <= fileAddr;
        if (fileWrEn)
            mem[addrQ] <= fileWrData;
    end
    assign fileRdData = mem[fileAddr];
endmodule // nsx_regfile_model

// File: nsx_exec_chk.sv
// port assertions for the execute block
`timescale 1ns/100ps
module nsx_exec_chk
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [13:0] instrWord,
    input wire logic        instrValid,
    input wire logic [7:0]  fileRdData,
    input wire logic [7:0]  fileWrData,
    input wire logic        fileWrEn,
    input wire logic [7:0]  acc,
    input wire logic        zeroFlag,
    input wire logic [7:0]  dirA
);
    logic [7:0]  rQ, aQ, sw;
    logic [13:0] wQ;
    logic        sq, xl, xf;
    // previous-cycle copies of operands
    always @(posedge clk)
    begin
        rQ <= fileRdData;
        aQ <= acc;
        wQ <= instrWord;
    end
    assign sw = {rQ[3:0], rQ[7:4]};
    assign sq = instrValid && instrWord[13:8] == 6'h0e;
    assign xl = instrValid && instrWord[13:8] == 6'h3a;
    assign xf = instrValid && instrWord[13:8] == 6'h06;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_swap_flag: assert property (sq |=> $stable(zeroFlag))
        else $error("swap changed zero flag");
    a_swap_acc: assert property (sq && !instrWord[7] |=>
        !fileWrEn && acc == sw) else $error("swap to acc wrong");
    a_swap_file: assert property (sq && instrWord[7] |=>
        fileWrEn && fileWrData == sw && $stable(acc))
        else $error("swap write-back wrong");
    a_xor_lit: assert property (xl |=> acc == (aQ ^ wQ[7:0]) &&
        zeroFlag == (acc == 8'h00)) else $error("literal xor wrong");
    a_xor_file: assert property (xf |=>
        (wQ[7] ? fileWrData : acc) == (aQ ^ rQ) &&
        zeroFlag == ((aQ ^ rQ) == 8'h00)) else $error("file xor wrong");
    a_dir_load: assert property (instrValid && instrWord == 14'h0065 |=>
        dirA == aQ && $stable(zeroFlag)) else $error("dir load wrong");
    c_swap_wb: cover property (sq && instrWord[7]);
    c_zero: cover property (xl ##1 zeroFlag);
    c_dir: cover property (instrValid && instrWord == 14'h0065);
endmodule // nsx_exec_chk
bind nsx_exec nsx_exec_chk chk_u (.*);

// File: nibble_swap_xor_exec_tb.sv
// self-checking bench for the execute block
`timescale 1ns/100ps
module nibble_swap_xor_exec_tb;
    logic        clk = 0, srst = 1, instrValid = 0, fileWrEn, zeroFlag, v;
    logic [13:0] instrWord = 14'h0000, w;
    logic [7:0]  fileRdData, fileWrData, acc, dirA, dirB, dirC;
    logic [6:0]  fileAddr;
    logic [31:0] seed = 32'ha5d4, r;
    integer err_count = 0, n_checks = 0, accM = 0, zM = 0, pw = 0, pa, pd;
    integer dirM [5:7] = '{255, 255, 255}, mem [0:127];
    nsx_exec dut_u (.clk(clk), .srst(srst), .instrWord(instrWord),
        .instrValid(instrValid), .fileRdData(fileRdData), .fileAddr(fileAddr),
        .fileWrData(fileWrData), .fileWrEn(fileWrEn), .acc(acc),
        .zeroFlag(zeroFlag), .dirA(dirA), .dirB(dirB), .dirC(dirC));
    nsx_regfile_model rf_u (.clk(clk), .fileAddr(fileAddr),
        .fileWrData(fileWrData), .fileWrEn(fileWrEn), .fileRdData(fileRdData));
    initial forever #12.5 clk = ~clk;
    initial #100000 begin err_count++; conclude; end
    function automatic logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task cmp(input [7:0] g, input [7:0] e);
        n_checks++;
        if (g !== e) err_count++;
        if (g !== e) $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one instruction through model and design, write one cycle late
    task step(input [13:0] w, input v);
        integer m, x;
        instrWord = w;
        instrValid = v;
        m = mem[w[6:0]];
        x = -1;
        if (pw) mem[pa] = pd;
        case (v ? w[13:8] : 6'h3f)
            6'h0e: x = {m[3:0], m[7:4]};
            6'h06: x = accM ^ m;
            6'h3a: accM = accM ^ w[7:0];
            6'h00: if (w[7:3] == 5'h0c && w[2:0] > 4) dirM[w[2:0]] = accM;
        endcase
        if (v && (w[13:8] == 6'h3a || w[13:8] == 6'h06))
            zM = (w[13] ? accM : x) == 0;
        pw = x >= 0 && w[7];
        pa = w[6:0];
        pd = x;
        if (x >= 0 && !w[7]) accM = x;
        @(posedge clk);
        #1;
        cmp(acc, accM);
        cmp(zeroFlag, zM);
        cmp(dirA, dirM[5]);
        cmp(dirB, dirM[6]);
        cmp(dirC, dirM[7]);
        cmp(fileWrEn, pw);
        cmp(fileAddr, w[6:0]);
        if (pw) cmp(fileWrData, pd);
    endtask
    initial
    begin
        for (int i = 0; i < 128; i++) mem[i] = i ^ 8'h5a;
        repeat (16) @(posedge clk);
        #1 srst = 0;
        cmp(acc, 8'h00);
        cmp(dirA, 8'hff);
        // random mix of group ops, refused ops and idle cycles
        repeat (400)
        begin
            r = rnd();
            w = r[13:0];
            v = r[18:16] != 7;
            case (r[18:16])
                0: w[13:8] = 6'h0e;
                1: w[13:8] = 6'h3a;
                2: w[13:8] = 6'h06;
                3: w[13:3] = 11'h00c;
                4: w[13:8] = 6'h07;
                5: w = {6'h3a, accM[7:0]};
                6: w[13:10] = 4'h0;
            endcase
            step(w, v);
        end
        $display("test random done");
        conclude;
    end
endmodule // nibble_swap_xor_exec_tb
